// [hdl/host_port_pkg.sv]
/*
  Constants, field layout and state codes for the byte-wide host port
  with read/write shadow registers.
  Assumes a single 10 MHz device clock and a synchronous active-low reset.
*/
// Overview of operation
// - Snapshot bytes readable in any order, any number of times, without change.
// - Each write stores the data byte into the staging byte chosen by A1..A0.
// - Write with update line high stores byte, then commits whole quadlet in one clock.
// - Unwritten staging bytes keep old values and go into the next commit.
// - Byte 0 is most significant; address 4N+k reaches byte k of register N.
// - Queues reached only via transfer register, moved automatically without processor.
// - Snapshot read of receive queue location moves head quadlet out, exposing next.
// - Transmit queue has next and final locations; final write marks packet complete.
// - Status flags tell when next queue quadlet can be read or written.
// - Active-low strobes and select, 9 address, 8 data lines, open-drain interrupt.
// - All host control inputs except A1..A0 for the read byte choice resampled into the device clock before use.
// - Read drives snapshot byte at once; update line refreshes snapshot later.
// - Register index bits ignored when update line is low.
// - Select, read and write strobes all low counts as a write.
// - Receive queues set available flag and flag each packet's final quadlet.
// - Receive queue read while its available flag is clear is a read error.
// - Snapshot byte output selected purely combinationally by A1..A0.
// - Sixty-four quadlet registers, six index bits, 256-byte byte space.
package host_port_pkg;
  localparam int HOST_DATA_W = 8;
  localparam int QUAD_W = 32;
  localparam int BYTES_PER_QUAD = 4;
  localparam int BYTE_SEL_W = 2;
  localparam int REG_IDX_W = 6;
  localparam int NUM_REGS = 64;
  localparam int CTRL_W = 3;
  localparam int QENTRY_W = QUAD_W + 1;
  localparam int CTRL_CS = 2;
  localparam int CTRL_RD = 1;
  localparam int CTRL_WR = 0;
  localparam logic [CTRL_W-1:0] CTRL_IDLE = 3'h7;
  localparam logic [REG_IDX_W-1:0] RX_REQ_IDX = 6'h38;
  localparam logic [REG_IDX_W-1:0] RX_RSP_IDX = 6'h39;
  localparam logic [REG_IDX_W-1:0] TX_REQ_NEXT_IDX = 6'h3A;
  localparam logic [REG_IDX_W-1:0] TX_REQ_LAST_IDX = 6'h3B;
  localparam logic [REG_IDX_W-1:0] TX_RSP_NEXT_IDX = 6'h3C;
  localparam logic [REG_IDX_W-1:0] TX_RSP_LAST_IDX = 6'h3D;
  localparam logic [REG_IDX_W-1:0] STATUS_IDX = 6'h3E;
  localparam int ST_RX_REQ_AVAIL = 7;
  localparam int ST_RX_REQ_LAST = 6;
  localparam int ST_RX_RSP_AVAIL = 5;
  localparam int ST_RX_RSP_LAST = 4;
  localparam int ST_TX_REQ_BUSY = 3;
  localparam int ST_TX_RSP_BUSY = 2;
  localparam int ST_RD_ERR = 1;
  localparam int ST_WR_ERR = 0;
  localparam logic [QUAD_W-1:0] QUAD_ZERO = 32'h0000_0000;
  localparam logic [HOST_DATA_W-1:0] BYTE_ZERO = 8'h00;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_READ = 4'b0010,
    ST_FETCH = 4'b0100,
    ST_WRITE = 4'b1000
  } access_state_t;
endpackage

// [hdl/pin_sync3.sv]
/*
  Three-flop resynchroniser with agreement filter for host pins.
  Assumes the inputs are asynchronous to clk; the output changes only
  when the second and third stages agree.
*/
module pin_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Pins and filtered result
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] stable_out
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
    end
    else
    begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Each bit follows only once two later stages agree
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      stable_out <= INIT;
    else
      stable_out <= (s2_r & ~(s2_r ^ s3_r)) | (stable_out & (s2_r ^ s3_r));
  end
endmodule

// [hdl/transfer_stage.sv]
/*
  One-entry transfer register between the host port and a packet queue.
  Assumes valid/ready handshakes on both sides in the clk domain.
*/
module transfer_stage #(
  parameter int WIDTH = 33
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  logic full_r;
  logic [WIDTH-1:0] data_r;

  assign in_ready = !full_r;
  assign out_valid = full_r;
  assign out_data = data_r;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      full_r <= 1'b0;
    else if (in_valid && !full_r)
      full_r <= 1'b1;
    else if (out_ready && full_r)
      full_r <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      data_r <= '0;
    else if (in_valid && !full_r)
      data_r <= in_data;
  end
endmodule

// [hdl/byte_host_port_shadow_regs.sv]
/*
  Byte-wide host port bridging an 8-bit processor bus to 64 internal
  quadlet registers and the asynchronous packet queues, via read and
  write shadow registers.
  Assumes the register space answers reg_rd_data combinationally from
  reg_rd_index, queues use valid/ready, and the processor keeps address
  and data stable for the whole strobe and leaves more than two clocks
  between accesses.
*/
module byte_host_port_shadow_regs
  import host_port_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Host bus pins
  input wire logic host_chip_select_n,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic byte_select_lo,
  input wire logic byte_select_hi,
  input wire logic [REG_IDX_W-1:0] register_index_bits,
  input wire logic shadow_update_line,
  input wire logic [HOST_DATA_W-1:0] host_data_bus_in,
  output logic [HOST_DATA_W-1:0] host_data_bus_out,
  output logic host_data_bus_oe,
  output logic host_irq_n_out,
  output logic host_irq_n_oe,
  // Internal register space
  output logic [REG_IDX_W-1:0] reg_rd_index,
  input wire logic [QUAD_W-1:0] reg_rd_data,
  output logic reg_wr_en,
  output logic [REG_IDX_W-1:0] reg_wr_index,
  output logic [QUAD_W-1:0] reg_wr_data,
  input wire logic irq_request,
  // Receive request queue
  input wire logic rx_request_queue_valid,
  input wire logic [QUAD_W-1:0] rx_request_queue_data,
  input wire logic rx_request_queue_last,
  output logic rx_request_queue_ready,
  // Receive response queue
  input wire logic rx_response_queue_valid,
  input wire logic [QUAD_W-1:0] rx_response_queue_data,
  input wire logic rx_response_queue_last,
  output logic rx_response_queue_ready,
  // Transmit request queue
  output logic tx_request_queue_valid,
  output logic [QUAD_W-1:0] tx_request_queue_data,
  output logic tx_request_queue_final,
  input wire logic tx_request_queue_ready,
  // Transmit response queue
  output logic tx_response_queue_valid,
  output logic [QUAD_W-1:0] tx_response_queue_data,
  output logic tx_response_queue_final,
  input wire logic tx_response_queue_ready,
  // Queue status
  output logic rx_request_available,
  output logic rx_response_available,
  output logic rx_request_final_quadlet,
  output logic rx_response_final_quadlet,
  output logic tx_request_busy,
  output logic tx_response_busy,
  output logic queue_read_error,
  output logic queue_write_error,
  input wire logic error_clear
);
  access_state_t state_r;
  access_state_t state_nxt;
  logic [CTRL_W-1:0] ctrl_s;
  logic [REG_IDX_W-1:0] idx_s;
  logic [BYTE_SEL_W-1:0] sel_s;
  logic upd_s;
  logic [HOST_DATA_W-1:0] data_s;
  logic wr_act;
  logic rd_act;
  logic wr_start;
  logic commit;
  logic [QUAD_W-1:0] staging_r;
  logic [QUAD_W-1:0] staging_nxt;
  logic [QUAD_W-1:0] snapshot_r;
  logic [REG_IDX_W-1:0] fetch_idx_r;
  logic in_fetch;
  logic rx_req_pop;
  logic rx_rsp_pop;
  logic rx_req_full;
  logic rx_rsp_full;
  logic [QENTRY_W-1:0] rx_req_head;
  logic [QENTRY_W-1:0] rx_rsp_head;
  logic tx_req_push;
  logic tx_rsp_push;
  logic tx_req_ready;
  logic tx_rsp_ready;
  logic tx_req_full;
  logic tx_rsp_full;
  logic is_final;
  logic [QUAD_W-1:0] status_word;
  logic queue_read_error_r;
  logic queue_write_error_r;
  logic oe_r;
  logic irq_oe_r;
  logic irq_level_r;
  logic [REG_IDX_W-1:0] reg_rd_index_r;
  logic reg_wr_en_r;
  logic [REG_IDX_W-1:0] reg_wr_index_r;
  logic [QUAD_W-1:0] reg_wr_data_r;

  // Byte k of a quadlet sits at the top for k = 0
  function automatic logic [QUAD_W-1:0] put_byte(input logic [QUAD_W-1:0] q,
                                                 input logic [BYTE_SEL_W-1:0] k,
                                                 input logic [HOST_DATA_W-1:0] b);
    logic [QUAD_W-1:0] r;
    r = q;
    r[QUAD_W-1-HOST_DATA_W*k -: HOST_DATA_W] = b;
    return r;
  endfunction

  function automatic logic [HOST_DATA_W-1:0] get_byte(input logic [QUAD_W-1:0] q,
                                                      input logic [BYTE_SEL_W-1:0] k);
    return q[QUAD_W-1-HOST_DATA_W*k -: HOST_DATA_W];
  endfunction

  // Host pins are resampled before use, except A1..A0 for the read byte choice
  pin_sync3 #(.WIDTH(CTRL_W), .INIT(CTRL_IDLE)) u_ctrl_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({host_chip_select_n, host_read_strobe_n, host_write_strobe_n}),
    .stable_out(ctrl_s)
  );

  pin_sync3 #(.WIDTH(REG_IDX_W + BYTE_SEL_W + 1 + HOST_DATA_W)) u_addr_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({shadow_update_line, register_index_bits, byte_select_hi, byte_select_lo,
               host_data_bus_in}),
    .stable_out({upd_s, idx_s, sel_s, data_s})
  );

  // All three strobes low is a write; read needs write strobe high
  assign wr_act = !ctrl_s[CTRL_CS] && !ctrl_s[CTRL_WR];
  assign rd_act = !ctrl_s[CTRL_CS] && !ctrl_s[CTRL_RD] && ctrl_s[CTRL_WR];
  assign wr_start = (state_r == ST_IDLE) && wr_act;
  assign commit = wr_start && upd_s;
  assign in_fetch = (state_r == ST_FETCH);
  assign staging_nxt = put_byte(staging_r, sel_s, data_s);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (wr_act)
          state_nxt = ST_WRITE;
        else if (rd_act && upd_s)
          state_nxt = ST_FETCH;
        else if (rd_act)
          state_nxt = ST_READ;
      end
      ST_FETCH:
        state_nxt = ST_READ;
      ST_READ:
      begin
        if (!rd_act)
          state_nxt = ST_IDLE;
      end
      ST_WRITE:
      begin
        if (!wr_act)
          state_nxt = ST_IDLE;
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Write staging: one byte per write cycle
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      staging_r <= QUAD_ZERO;
    else if (wr_start)
      staging_r <= staging_nxt;
  end

  // Commit to register space or a transmit transfer register
  assign is_final = (idx_s == TX_REQ_LAST_IDX) || (idx_s == TX_RSP_LAST_IDX);
  assign tx_req_push = commit && (idx_s == TX_REQ_NEXT_IDX || idx_s == TX_REQ_LAST_IDX);
  assign tx_rsp_push = commit && (idx_s == TX_RSP_NEXT_IDX || idx_s == TX_RSP_LAST_IDX);

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      reg_wr_en_r <= 1'b0;
      reg_wr_index_r <= '0;
      reg_wr_data_r <= QUAD_ZERO;
    end
    else
    begin
      reg_wr_en_r <= commit && idx_s < RX_REQ_IDX;
      if (commit)
      begin
        reg_wr_index_r <= idx_s;
        reg_wr_data_r <= staging_nxt;
      end
    end
  end

  // Transmit transfer registers drain to the queues on their own
  transfer_stage #(.WIDTH(QENTRY_W)) u_tx_req (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(tx_req_push),
    .in_data({is_final, staging_nxt}),
    .in_ready(tx_req_ready),
    .out_valid(tx_req_full),
    .out_data({tx_request_queue_final, tx_request_queue_data}),
    .out_ready(tx_request_queue_ready)
  );

  transfer_stage #(.WIDTH(QENTRY_W)) u_tx_rsp (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(tx_rsp_push),
    .in_data({is_final, staging_nxt}),
    .in_ready(tx_rsp_ready),
    .out_valid(tx_rsp_full),
    .out_data({tx_response_queue_final, tx_response_queue_data}),
    .out_ready(tx_response_queue_ready)
  );

  assign tx_request_queue_valid = tx_req_full;
  assign tx_response_queue_valid = tx_rsp_full;

  // Receive transfer registers prefetch the queue head
  transfer_stage #(.WIDTH(QENTRY_W)) u_rx_req (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(rx_request_queue_valid),
    .in_data({rx_request_queue_last, rx_request_queue_data}),
    .in_ready(rx_request_queue_ready),
    .out_valid(rx_req_full),
    .out_data(rx_req_head),
    .out_ready(rx_req_pop)
  );

  transfer_stage #(.WIDTH(QENTRY_W)) u_rx_rsp (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(rx_response_queue_valid),
    .in_data({rx_response_queue_last, rx_response_queue_data}),
    .in_ready(rx_response_queue_ready),
    .out_valid(rx_rsp_full),
    .out_data(rx_rsp_head),
    .out_ready(rx_rsp_pop)
  );

  assign rx_req_pop = in_fetch && (fetch_idx_r == RX_REQ_IDX) && rx_req_full;
  assign rx_rsp_pop = in_fetch && (fetch_idx_r == RX_RSP_IDX) && rx_rsp_full;

  // Status presented to the register space and to the processor
  assign rx_request_available = rx_req_full;
  assign rx_response_available = rx_rsp_full;
  // A stale last bit of an already popped quadlet must not show
  assign rx_request_final_quadlet = rx_req_full && rx_req_head[QUAD_W];
  assign rx_response_final_quadlet = rx_rsp_full && rx_rsp_head[QUAD_W];
  assign tx_request_busy = tx_req_full;
  assign tx_response_busy = tx_rsp_full;

  always_comb
  begin
    status_word = QUAD_ZERO;
    status_word[ST_RX_REQ_AVAIL] = rx_req_full;
    status_word[ST_RX_REQ_LAST] = rx_req_full && rx_req_head[QUAD_W];
    status_word[ST_RX_RSP_AVAIL] = rx_rsp_full;
    status_word[ST_RX_RSP_LAST] = rx_rsp_full && rx_rsp_head[QUAD_W];
    status_word[ST_TX_REQ_BUSY] = tx_req_full;
    status_word[ST_TX_RSP_BUSY] = tx_rsp_full;
    status_word[ST_RD_ERR] = queue_read_error_r;
    status_word[ST_WR_ERR] = queue_write_error_r;
  end

  // Read target is latched at the start of an updating read
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      fetch_idx_r <= '0;
      reg_rd_index_r <= '0;
    end
    else if (state_r == ST_IDLE && rd_act && !wr_act && upd_s)
    begin
      fetch_idx_r <= idx_s;
      reg_rd_index_r <= idx_s;
    end
  end

  // Snapshot changes only on an updating read
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      snapshot_r <= QUAD_ZERO;
    else if (in_fetch)
    begin
      case (fetch_idx_r)
        RX_REQ_IDX:
        begin
          if (rx_req_full)
            snapshot_r <= rx_req_head[QUAD_W-1:0];
        end
        RX_RSP_IDX:
        begin
          if (rx_rsp_full)
            snapshot_r <= rx_rsp_head[QUAD_W-1:0];
        end
        STATUS_IDX:
          snapshot_r <= status_word;
        default:
          snapshot_r <= reg_rd_data;
      endcase
    end
  end

  // Sticky errors; a new error wins over a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      queue_read_error_r <= 1'b0;
    else if (in_fetch && ((fetch_idx_r == RX_REQ_IDX && !rx_req_full) ||
                          (fetch_idx_r == RX_RSP_IDX && !rx_rsp_full)))
      queue_read_error_r <= 1'b1;
    else if (error_clear)
      queue_read_error_r <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      queue_write_error_r <= 1'b0;
    else if ((tx_req_push && !tx_req_ready) || (tx_rsp_push && !tx_rsp_ready))
      queue_write_error_r <= 1'b1;
    else if (error_clear)
      queue_write_error_r <= 1'b0;
  end

  assign queue_read_error = queue_read_error_r;
  assign queue_write_error = queue_write_error_r;

  // Data bus drive and open-drain interrupt
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      oe_r <= 1'b0;
    else
      oe_r <= (state_nxt == ST_READ) || (state_nxt == ST_FETCH);
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      irq_oe_r <= 1'b0;
      irq_level_r <= 1'b0;
    end
    else
    begin
      irq_oe_r <= irq_request;
      irq_level_r <= 1'b0;
    end
  end

  // Byte chosen straight from the pins so the host may sweep it in one read
  assign host_data_bus_out = oe_r ? get_byte(snapshot_r, {byte_select_hi, byte_select_lo})
                                  : BYTE_ZERO;
  assign host_data_bus_oe = oe_r;
  assign host_irq_n_out = irq_level_r;
  assign host_irq_n_oe = irq_oe_r;
  assign reg_rd_index = reg_rd_index_r;
  assign reg_wr_en = reg_wr_en_r;
  assign reg_wr_index = reg_wr_index_r;
  assign reg_wr_data = reg_wr_data_r;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_read_hold;
    (state_r == ST_READ) ##1 (state_r == ST_READ);
  endsequence

  sequence s_rx_req_fetch;
    in_fetch && fetch_idx_r == RX_REQ_IDX;
  endsequence

  property p_snapshot_hold;
    s_read_hold |-> $stable(snapshot_r);
  endproperty
  a_snapshot_hold: assert property (p_snapshot_hold) else $error("snapshot moved in read");

  property p_byte_store;
    wr_start |=> get_byte(staging_r, $past(sel_s)) == $past(data_s);
  endproperty
  a_byte_store: assert property (p_byte_store) else $error("staging byte not stored");

  property p_commit;
    (commit && idx_s < RX_REQ_IDX) |=> reg_wr_en_r && reg_wr_data_r == $past(staging_nxt)
      && reg_wr_index_r == $past(idx_s);
  endproperty
  a_commit: assert property (p_commit) else $error("commit missing or wrong");

  property p_keep_old;
    wr_start |=> get_byte(staging_r, $past(sel_s) + 2'h1) ==
                 get_byte($past(staging_r), $past(sel_s) + 2'h1);
  endproperty
  a_keep_old: assert property (p_keep_old) else $error("unwritten byte changed");

  property p_no_update;
    (wr_start && !upd_s) |=> !reg_wr_en_r ##0 !tx_req_full || $past(tx_req_full);
  endproperty
  a_no_update: assert property (p_no_update) else $error("commit without update");

  property p_rx_pop;
    (s_rx_req_fetch and rx_req_full) |=> snapshot_r == $past(rx_req_head[QUAD_W-1:0])
      ##1 state_r != ST_FETCH;
  endproperty
  a_rx_pop: assert property (p_rx_pop) else $error("receive head not moved");

  property p_read_err;
    (s_rx_req_fetch and !rx_req_full) |=> queue_read_error_r;
  endproperty
  a_read_err: assert property (p_read_err) else $error("read error not flagged");

  property p_write_wins;
    (state_r == ST_IDLE && ctrl_s == 3'h0) |=> state_r == ST_WRITE;
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("all low not a write");

  property p_tx_final;
    (commit && idx_s == TX_REQ_LAST_IDX && tx_req_ready) |=> tx_req_full
      && tx_request_queue_final;
  endproperty
  a_tx_final: assert property (p_tx_final) else $error("final quadlet not marked");
endmodule

// [sim/reg_space_model.sv]
/*
  Behavioural model of the 64-quadlet internal register space.
  Assumes reads are answered combinationally and writes land on the
  clock edge that sees the write enable.
*/
module reg_space_model
  import host_port_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register port
  input wire logic [REG_IDX_W-1:0] rd_index,
  output logic [QUAD_W-1:0] rd_data,
  input wire logic wr_en,
  input wire logic [REG_IDX_W-1:0] wr_index,
  input wire logic [QUAD_W-1:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [QUAD_W-1:0] mem [NUM_REGS];
  initial mem = '{default: QUAD_ZERO};
  assign rd_data = mem[rd_index];
  always @(posedge clk)
    if (wr_en)
      mem[wr_index] <= wr_data;
endmodule

// [sim/byte_host_port_shadow_regs_tb.sv]
/*
  Bench for the byte-wide host port: host cycles driven on falling edges.
  Assumes the register space model and a pull-up on the interrupt pin.
*/
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module byte_host_port_shadow_regs_tb
  import host_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, cs_n, rd_n, wr_n, a0, a1, upd, irq_req, err_clr, doe, irq_o, irq_oe;
  logic wen, rd_err, wr_err;
  logic [5:0] idx, rdi, wri;
  logic [7:0] din, dout, drv;
  logic [31:0] rdd, wrd, q;
  logic [1:0] rxv, rxl, rxr, txv, txf, txr, rx_av, rx_fin, tx_busy;
  logic [31:0] rxd [2];
  logic [31:0] txd [2];
  wire irq_pin = irq_oe ? irq_o : 1'b1;
  int n_errors = 0;
  int checks_done = 0;
  assign din = doe ? dout : drv;
  byte_host_port_shadow_regs byte_host_port_shadow_regs_i (
    .clk(clk), .reset_n(reset_n), .host_chip_select_n(cs_n), .host_read_strobe_n(rd_n),
    .host_write_strobe_n(wr_n), .byte_select_lo(a0), .byte_select_hi(a1),
    .register_index_bits(idx), .shadow_update_line(upd), .host_data_bus_in(din),
    .host_data_bus_out(dout), .host_data_bus_oe(doe), .host_irq_n_out(irq_o),
    .host_irq_n_oe(irq_oe), .reg_rd_index(rdi), .reg_rd_data(rdd), .reg_wr_en(wen),
    .reg_wr_index(wri), .reg_wr_data(wrd), .irq_request(irq_req),
    .rx_request_queue_valid(rxv[0]), .rx_request_queue_data(rxd[0]),
    .rx_request_queue_last(rxl[0]), .rx_request_queue_ready(rxr[0]),
    .rx_response_queue_valid(rxv[1]), .rx_response_queue_data(rxd[1]),
    .rx_response_queue_last(rxl[1]), .rx_response_queue_ready(rxr[1]),
    .tx_request_queue_valid(txv[0]), .tx_request_queue_data(txd[0]),
    .tx_request_queue_final(txf[0]), .tx_request_queue_ready(txr[0]),
    .tx_response_queue_valid(txv[1]), .tx_response_queue_data(txd[1]),
    .tx_response_queue_final(txf[1]), .tx_response_queue_ready(txr[1]),
    .rx_request_available(rx_av[0]), .rx_response_available(rx_av[1]),
    .rx_request_final_quadlet(rx_fin[0]), .rx_response_final_quadlet(rx_fin[1]),
    .tx_request_busy(tx_busy[0]), .tx_response_busy(tx_busy[1]),
    .queue_read_error(rd_err), .queue_write_error(wr_err), .error_clear(err_clr)
  );
  reg_space_model reg_space_model_i (
    .clk(clk), .rd_index(rdi), .rd_data(rdd), .wr_en(wen), .wr_index(wri), .wr_data(wrd)
  );
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One host cycle; a read sweeps all four bytes within the same strobe
  task automatic acc(input bit w, input bit u, input bit rx, input logic [5:0] i,
                     input logic [1:0] k, input logic [7:0] d);
    @(negedge clk);
    upd = u; // Update line high stands for byte address plus 256
    idx = i;
    {a1, a0} = k;
    drv = d;
    cs_n = 1'b0;
    wr_n = !w;
    rd_n = w && !rx;
    repeat (10) @(negedge clk);
    if (!w)
      for (int b = 0; b < 4; b++)
      begin
        {a1, a0} = b[1:0];
        #1 q[31 - 8*b -: 8] = din; // All four bytes fetched before any other read
      end
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    repeat (6) @(negedge clk); // Idle gap well over two clocks
  endtask
  // Quadlet write with the update raised on byte 3 only
  task automatic wq(input logic [5:0] i, input logic [31:0] v);
    for (int b = 0; b < 4; b++)
      acc(1'b1, b == 3, 1'b0, i, b[1:0], v[31 - 8*b -: 8]);
  endtask
  task automatic clear_err;
    @(negedge clk) err_clr = 1'b1;
    @(negedge clk) err_clr = 1'b0;
    @(negedge clk);
    `CHK({rd_err, wr_err}, 2'b00)
  endtask
  initial
  begin
    #500000;
    n_errors++;
    finish_test();
  end
  initial
  begin
    {cs_n, rd_n, wr_n, a0, a1, upd, irq_req, err_clr, reset_n} = 9'h1C0;
    {idx, drv, rxv, rxl, txr} = '0;
    rxd = '{QUAD_ZERO, QUAD_ZERO};
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    `CHK({doe, rd_err, wr_err, txv}, 5'h00)
    wq(6'h05, 32'hA1B2C3D4);
    `CHK(reg_space_model_i.mem[5], 32'hA1B2C3D4)
    acc(1'b0, 1'b1, 1'b0, 6'h05, 2'h0, 8'h00);
    `CHK(q, 32'hA1B2C3D4)
    acc(1'b0, 1'b0, 1'b0, 6'h2A, 2'h3, 8'h00);
    `CHK(q, 32'hA1B2C3D4)
    acc(1'b1, 1'b0, 1'b0, 6'h09, 2'h0, 8'h77);
    `CHK(reg_space_model_i.mem[9], QUAD_ZERO)
    acc(1'b1, 1'b1, 1'b0, 6'h07, 2'h3, 8'h5E);
    `CHK(reg_space_model_i.mem[7], 32'h77B2C35E)
    acc(1'b1, 1'b1, 1'b1, 6'h08, 2'h3, 8'h99);
    `CHK(reg_space_model_i.mem[8], 32'h77B2C399)
    for (int j = 0; j < 2; j++)
    begin
      @(negedge clk);
      rxd[j] = 32'h1000_0001 + j;
      rxv[j] = 1'b1;
      rxl[j] = 1'b1;
      @(negedge clk);
      rxv[j] = 1'b0;
      @(negedge clk);
      `CHK({rx_av[j], rx_fin[j], rxr[j]}, 3'b110)
      acc(1'b0, 1'b1, 1'b0, 6'(RX_REQ_IDX + j), 2'h0, 8'h00);
      `CHK({rx_av[j], rxr[j], q}, {2'b01, 32'h1000_0001 + j})
      acc(1'b0, 1'b1, 1'b0, 6'(RX_REQ_IDX + j), 2'h0, 8'h00);
      `CHK({rd_err, q}, {1'b1, 32'h1000_0001 + j})
      clear_err();
    end
    for (int j = 0; j < 2; j++)
    begin
      wq(6'(TX_REQ_NEXT_IDX + 2*j), 32'hCAFE_0000 + j);
      `CHK({txv[j], txf[j], tx_busy[j], txd[j]}, {3'b101, 32'hCAFE_0000 + j})
      wq(6'(TX_REQ_LAST_IDX + 2*j), 32'h0BAD_0000);
      `CHK({wr_err, txd[j]}, {1'b1, 32'hCAFE_0000 + j})
      acc(1'b0, 1'b1, 1'b0, STATUS_IDX, 2'h0, 8'h00);
      `CHK(q, {28'h0, 1'b1, j == 1, 2'b01})
      @(negedge clk) txr[j] = 1'b1;
      @(negedge clk) txr[j] = 1'b0;
      `CHK({txv[j], tx_busy[j]}, 2'b00)
      wq(6'(TX_REQ_LAST_IDX + 2*j), 32'hF1A1_0000 + j);
      `CHK({txv[j], txf[j], txd[j]}, {2'b11, 32'hF1A1_0000 + j})
      clear_err();
    end
    irq_req = 1'b1;
    repeat (2) @(negedge clk);
    `CHK(irq_pin, 1'b0)
    irq_req = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(irq_pin, 1'b1)
    finish_test();
  end
endmodule
